// ---- rtl/tsl_pkg.sv ----
// Constants, types and register map of the touch ADC limit and sequence register bank
package tsl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int IDX_W = 5;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_ALERT = 5'h03;
  localparam logic [4:0] IDX_BAT1_HI = 5'h06;
  localparam logic [4:0] IDX_BAT1_LO = 5'h07;
  localparam logic [4:0] IDX_BAT2_HI = 5'h08;
  localparam logic [4:0] IDX_BAT2_LO = 5'h09;
  localparam logic [4:0] IDX_TEMP_LO = 5'h0A;
  localparam logic [4:0] IDX_TEMP_HI = 5'h0B;
  localparam logic [4:0] IDX_SLV_SEQ = 5'h0C;
  localparam logic [4:0] IDX_MST_SEQ = 5'h0D;
  localparam logic [4:0] IDX_ANA_OUT = 5'h0E;

  // ----------------------------------------------------------------
  // Reset values and field layouts
  // ----------------------------------------------------------------
  localparam logic [11:0] LIMIT_RST = 12'h000;
  localparam logic [11:0] SEQ_RST = 12'h000;
  localparam logic [11:0] ANA_OUT_RST = 12'h008;
  localparam logic [11:0] ALERT_RST = 12'h000;
  localparam logic [11:0] SEQ_USED_MASK = 12'hFFE;
  localparam logic [11:0] ANA_USED_MASK = 12'hFFD;
  localparam logic [11:0] ALERT_USED_MASK = 12'hEEE;
  localparam int ANALOG_CODE_LSB = 4;
  localparam int ANALOG_CODE_MSB = 11;
  localparam int BATTERY_ONE_UNDER_FLAG = 1;
  localparam int BATTERY_TWO_UNDER_FLAG = 2;
  localparam int TEMPERATURE_UNDER_FLAG = 3;
  localparam int BATTERY_ONE_OVER_FLAG = 5;
  localparam int BATTERY_TWO_OVER_FLAG = 6;
  localparam int TEMPERATURE_OVER_FLAG = 7;
  localparam int BATTERY_ONE_ALARM_ENABLE = 9;
  localparam int BATTERY_TWO_ALARM_ENABLE = 10;
  localparam int TEMPERATURE_ALARM_ENABLE = 11;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } tsl_bus_state_t;

  typedef struct packed {
    logic valid;
    logic [11:0] data;
  } tsl_result_t;

  typedef struct packed {
    logic y_position_in_slave_seq;
    logic x_position_in_slave_seq;
    logic pressure_second_in_slave_seq;
    logic auxiliary_one_in_slave_seq;
    logic auxiliary_two_in_slave_seq;
    logic auxiliary_three_in_slave_seq;
    logic battery_one_in_slave_seq;
    logic battery_two_in_slave_seq;
    logic single_temperature_in_slave_seq;
    logic diff_temperature_in_slave_seq;
    logic pressure_first_in_slave_seq;
    logic unused;
  } tsl_slave_seq_t;

  typedef struct packed {
    logic y_position_in_master_seq;
    logic x_position_in_master_seq;
    logic pressure_second_in_master_seq;
    logic auxiliary_one_in_master_seq;
    logic auxiliary_two_in_master_seq;
    logic auxiliary_three_in_master_seq;
    logic battery_one_in_master_seq;
    logic battery_two_in_master_seq;
    logic single_temperature_in_master_seq;
    logic diff_temperature_in_master_seq;
    logic pressure_first_in_master_seq;
    logic unused;
  } tsl_master_seq_t;

  typedef struct packed {
    logic [7:0] analog_code;
    logic analog_out_sleep;
    logic current_mode;
    logic unused;
    logic full_span;
  } tsl_ana_out_t;

endpackage

// ---- rtl/tsl_limit_cmp.sv ----
// Window comparator that checks one conversion result against its limits
`timescale 1ns/10ps
module tsl_limit_cmp #(
  parameter int W = 12
) (
  input logic result_valid,
  input logic [W-1:0] result_data,
  input logic [W-1:0] low_limit,
  input logic [W-1:0] high_limit,
  output logic under_hit,
  output logic over_hit
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  // Plain logic vectors keep both sides unsigned
  assign under_hit = result_valid && (result_data < low_limit);
  assign over_hit = result_valid && (result_data > high_limit);

endmodule

// ---- rtl/tsl_regs.sv ----
// Register bank with AHB-Lite slave, limit alarms and alert output
`timescale 1ns/10ps
module tsl_regs #(
  parameter int ADDR_W = 32
) (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [ADDR_W-1:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input tsl_pkg::tsl_result_t battery_one_result,
  input tsl_pkg::tsl_result_t battery_two_result,
  input tsl_pkg::tsl_result_t temperature_result,
  output tsl_pkg::tsl_slave_seq_t slave_sequence_mask,
  output tsl_pkg::tsl_master_seq_t master_sequence_mask,
  output tsl_pkg::tsl_ana_out_t analog_out_control,
  output logic alert
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tsl_pkg::tsl_bus_state_t state_ff;
  tsl_pkg::tsl_bus_state_t nxt_state;
  logic accept;
  logic addr_hit;
  logic [4:0] dp_idx_ff;
  logic dp_hit_ff;
  logic wr_en;
  logic [11:0] wdata;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  logic [11:0] bat1_hi_ff;
  logic [11:0] bat1_lo_ff;
  logic [11:0] bat2_hi_ff;
  logic [11:0] bat2_lo_ff;
  logic [11:0] temp_lo_ff;
  logic [11:0] temp_hi_ff;
  logic [11:0] slv_seq_ff;
  logic [11:0] mst_seq_ff;
  logic [11:0] ana_out_ff;
  logic [11:0] alert_reg_ff;
  logic [11:0] nxt_alert_reg;
  logic [11:0] alarm_set;
  logic alert_ff;
  logic bat1_under;
  logic bat1_over;
  logic bat2_under;
  logic bat2_over;
  logic temp_under;
  logic temp_over;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready
  assign accept = hsel && htrans[1] && hready;

  // Only aligned words inside the low index window are mapped
  always_comb begin
    addr_hit = (haddr[1:0] == 2'h0) && (haddr[ADDR_W-1:7] == '0);
    case (haddr[6:2])
      tsl_pkg::IDX_ALERT,
      tsl_pkg::IDX_BAT1_HI,
      tsl_pkg::IDX_BAT1_LO,
      tsl_pkg::IDX_BAT2_HI,
      tsl_pkg::IDX_BAT2_LO,
      tsl_pkg::IDX_TEMP_LO,
      tsl_pkg::IDX_TEMP_HI,
      tsl_pkg::IDX_SLV_SEQ,
      tsl_pkg::IDX_MST_SEQ,
      tsl_pkg::IDX_ANA_OUT: addr_hit = addr_hit;
      default: addr_hit = 1'b0;
    endcase
  end

  // Address phase capture for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_idx_ff <= 5'h00;
      dp_hit_ff <= 1'b0;
    end else if (accept) begin
      dp_idx_ff <= haddr[6:2];
      dp_hit_ff <= addr_hit;
    end
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Reads take one wait state so a read right after a write sees it
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tsl_pkg::BUS_IDLE,
      tsl_pkg::BUS_WRITE,
      tsl_pkg::BUS_READ_DONE: begin
        if (accept) begin
          nxt_state = hwrite ? tsl_pkg::BUS_WRITE : tsl_pkg::BUS_READ_WAIT;
        end else begin
          nxt_state = tsl_pkg::BUS_IDLE;
        end
      end
      tsl_pkg::BUS_READ_WAIT: nxt_state = tsl_pkg::BUS_READ_DONE;
      default: nxt_state = tsl_pkg::BUS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= tsl_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ready is low only in the read wait cycle; response is always OKAY
  assign hreadyout = (state_ff != tsl_pkg::BUS_READ_WAIT);
  assign hresp = tsl_pkg::HRESP_OKAY;

  // ----------------------------------------------------------------
  // Write strobe
  // ----------------------------------------------------------------
  // Writes land at the end of the data phase; unmapped ones are dropped
  assign wr_en = (state_ff == tsl_pkg::BUS_WRITE) && dp_hit_ff;
  assign wdata = hwdata[11:0];

  // ----------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------
  // Battery one limits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bat1_hi_ff <= tsl_pkg::LIMIT_RST;
      bat1_lo_ff <= tsl_pkg::LIMIT_RST;
    end else if (wr_en) begin
      if (dp_idx_ff == tsl_pkg::IDX_BAT1_HI) begin
        bat1_hi_ff <= wdata;
      end
      if (dp_idx_ff == tsl_pkg::IDX_BAT1_LO) begin
        bat1_lo_ff <= wdata;
      end
    end
  end

  // Battery two limits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bat2_hi_ff <= tsl_pkg::LIMIT_RST;
      bat2_lo_ff <= tsl_pkg::LIMIT_RST;
    end else if (wr_en) begin
      if (dp_idx_ff == tsl_pkg::IDX_BAT2_HI) begin
        bat2_hi_ff <= wdata;
      end
      if (dp_idx_ff == tsl_pkg::IDX_BAT2_LO) begin
        bat2_lo_ff <= wdata;
      end
    end
  end

  // Temperature limits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_lo_ff <= tsl_pkg::LIMIT_RST;
      temp_hi_ff <= tsl_pkg::LIMIT_RST;
    end else if (wr_en) begin
      if (dp_idx_ff == tsl_pkg::IDX_TEMP_LO) begin
        temp_lo_ff <= wdata;
      end
      if (dp_idx_ff == tsl_pkg::IDX_TEMP_HI) begin
        temp_hi_ff <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence masks
  // ----------------------------------------------------------------
  // Bit 0 is not used and always holds zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slv_seq_ff <= tsl_pkg::SEQ_RST;
      mst_seq_ff <= tsl_pkg::SEQ_RST;
    end else if (wr_en) begin
      if (dp_idx_ff == tsl_pkg::IDX_SLV_SEQ) begin
        slv_seq_ff <= wdata & tsl_pkg::SEQ_USED_MASK;
      end
      if (dp_idx_ff == tsl_pkg::IDX_MST_SEQ) begin
        mst_seq_ff <= wdata & tsl_pkg::SEQ_USED_MASK;
      end
    end
  end

  // Masks steer the sequencer outside this bank
  assign slave_sequence_mask = tsl_pkg::tsl_slave_seq_t'(slv_seq_ff);
  assign master_sequence_mask = tsl_pkg::tsl_master_seq_t'(mst_seq_ff);

  // ----------------------------------------------------------------
  // Analog output control
  // ----------------------------------------------------------------
  // Starts asleep; bit 1 is not used and holds zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_out_ff <= tsl_pkg::ANA_OUT_RST;
    end else if (wr_en && (dp_idx_ff == tsl_pkg::IDX_ANA_OUT)) begin
      ana_out_ff <= wdata & tsl_pkg::ANA_USED_MASK;
    end
  end

  // Span bit only matters while the output is in voltage mode
  assign analog_out_control = tsl_pkg::tsl_ana_out_t'(ana_out_ff);

  // ----------------------------------------------------------------
  // Limit comparators
  // ----------------------------------------------------------------
  tsl_limit_cmp #(
    .W(tsl_pkg::DATA_W)
  ) u_cmp_bat1 (
    .result_valid(battery_one_result.valid),
    .result_data(battery_one_result.data),
    .low_limit(bat1_lo_ff),
    .high_limit(bat1_hi_ff),
    .under_hit(bat1_under),
    .over_hit(bat1_over)
  );

  tsl_limit_cmp #(
    .W(tsl_pkg::DATA_W)
  ) u_cmp_bat2 (
    .result_valid(battery_two_result.valid),
    .result_data(battery_two_result.data),
    .low_limit(bat2_lo_ff),
    .high_limit(bat2_hi_ff),
    .under_hit(bat2_under),
    .over_hit(bat2_over)
  );

  tsl_limit_cmp #(
    .W(tsl_pkg::DATA_W)
  ) u_cmp_temp (
    .result_valid(temperature_result.valid),
    .result_data(temperature_result.data),
    .low_limit(temp_lo_ff),
    .high_limit(temp_hi_ff),
    .under_hit(temp_under),
    .over_hit(temp_over)
  );

  // ----------------------------------------------------------------
  // Alarm flags and enables
  // ----------------------------------------------------------------
  // Map comparator hits onto their flag positions
  always_comb begin
    alarm_set = 12'h000;
    alarm_set[tsl_pkg::BATTERY_ONE_UNDER_FLAG] = bat1_under;
    alarm_set[tsl_pkg::BATTERY_TWO_UNDER_FLAG] = bat2_under;
    alarm_set[tsl_pkg::TEMPERATURE_UNDER_FLAG] = temp_under;
    alarm_set[tsl_pkg::BATTERY_ONE_OVER_FLAG] = bat1_over;
    alarm_set[tsl_pkg::BATTERY_TWO_OVER_FLAG] = bat2_over;
    alarm_set[tsl_pkg::TEMPERATURE_OVER_FLAG] = temp_over;
  end

  // Software writes the register; a hit in the same cycle still sets
  always_comb begin
    nxt_alert_reg = alert_reg_ff;
    if (wr_en && (dp_idx_ff == tsl_pkg::IDX_ALERT)) begin
      nxt_alert_reg = wdata & tsl_pkg::ALERT_USED_MASK;
    end
    nxt_alert_reg = nxt_alert_reg | alarm_set;
  end

  // Flags are sticky until software writes them clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_reg_ff <= tsl_pkg::ALERT_RST;
    end else begin
      alert_reg_ff <= nxt_alert_reg;
    end
  end

  // ----------------------------------------------------------------
  // Alert output
  // ----------------------------------------------------------------
  // A flag reaches the pin only through its channel enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_ff <= 1'b0;
    end else begin
      alert_ff <=
        (alert_reg_ff[tsl_pkg::BATTERY_ONE_ALARM_ENABLE] &&
         (alert_reg_ff[tsl_pkg::BATTERY_ONE_UNDER_FLAG] ||
          alert_reg_ff[tsl_pkg::BATTERY_ONE_OVER_FLAG])) ||
        (alert_reg_ff[tsl_pkg::BATTERY_TWO_ALARM_ENABLE] &&
         (alert_reg_ff[tsl_pkg::BATTERY_TWO_UNDER_FLAG] ||
          alert_reg_ff[tsl_pkg::BATTERY_TWO_OVER_FLAG])) ||
        (alert_reg_ff[tsl_pkg::TEMPERATURE_ALARM_ENABLE] &&
         (alert_reg_ff[tsl_pkg::TEMPERATURE_UNDER_FLAG] ||
          alert_reg_ff[tsl_pkg::TEMPERATURE_OVER_FLAG]));
    end
  end

  assign alert = alert_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux over the captured index; unmapped reads give zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (dp_hit_ff) begin
      case (dp_idx_ff)
        tsl_pkg::IDX_ALERT: nxt_rdata[11:0] = alert_reg_ff;
        tsl_pkg::IDX_BAT1_HI: nxt_rdata[11:0] = bat1_hi_ff;
        tsl_pkg::IDX_BAT1_LO: nxt_rdata[11:0] = bat1_lo_ff;
        tsl_pkg::IDX_BAT2_HI: nxt_rdata[11:0] = bat2_hi_ff;
        tsl_pkg::IDX_BAT2_LO: nxt_rdata[11:0] = bat2_lo_ff;
        tsl_pkg::IDX_TEMP_LO: nxt_rdata[11:0] = temp_lo_ff;
        tsl_pkg::IDX_TEMP_HI: nxt_rdata[11:0] = temp_hi_ff;
        tsl_pkg::IDX_SLV_SEQ: nxt_rdata[11:0] = slv_seq_ff;
        tsl_pkg::IDX_MST_SEQ: nxt_rdata[11:0] = mst_seq_ff;
        tsl_pkg::IDX_ANA_OUT: nxt_rdata[11:0] = ana_out_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data is loaded in the wait cycle and held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (state_ff == tsl_pkg::BUS_READ_WAIT) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = hrdata_ff;

  // hsize is not checked: only whole-word transfers are expected
  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:12], htrans[0]};

endmodule

// ---- testbench/tsl_regs_assertions.sv ----
// Port checks for the limit, sequence and analog output register bank
`timescale 1ns/10ps
module tsl_regs_checker #(
  parameter int ADDR_W = 32
) (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [ADDR_W-1:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input tsl_pkg::tsl_result_t battery_one_result,
  input tsl_pkg::tsl_result_t battery_two_result,
  input tsl_pkg::tsl_result_t temperature_result,
  input tsl_pkg::tsl_slave_seq_t slave_sequence_mask,
  input tsl_pkg::tsl_master_seq_t master_sequence_mask,
  input tsl_pkg::tsl_ana_out_t analog_out_control,
  input logic alert
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic take_w;
  logic any_res;
  logic ana_wr_ff;
  logic slv_wr_ff;
  logic mst_wr_ff;
  logic alr_wr_ff;
  // Write taken and result pulses of any channel
  assign take_w = hsel && htrans[1] && hready && hwrite;
  assign any_res = battery_one_result.valid || battery_two_result.valid
    || temperature_result.valid;
  function automatic logic hit(input logic [4:0] i);
    return take_w && (haddr == ADDR_W'({i, 2'b00}));
  endfunction
  // Marks the data phase of a write to each watched register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ana_wr_ff <= 1'b0;
      slv_wr_ff <= 1'b0;
      mst_wr_ff <= 1'b0;
      alr_wr_ff <= 1'b0;
    end else begin
      ana_wr_ff <= hit(tsl_pkg::IDX_ANA_OUT);
      slv_wr_ff <= hit(tsl_pkg::IDX_SLV_SEQ);
      mst_wr_ff <= hit(tsl_pkg::IDX_MST_SEQ);
      alr_wr_ff <= hit(tsl_pkg::IDX_ALERT);
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == tsl_pkg::HRESP_OKAY)
    else $error("response not OKAY");
  a_read_wait: assert property (s_read_taken |=> s_one_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take_w |=> hreadyout)
    else $error("write stalled");
  a_rdata_upper: assert property (hrdata[31:12] == 20'h00000)
    else $error("upper read bits set");
  a_unused_zero: assert property (!slave_sequence_mask.unused
    && !master_sequence_mask.unused && !analog_out_control.unused)
    else $error("unused bit set");
  a_dac_lands: assert property (ana_wr_ff && hready |=>
    analog_out_control == ($past(hwdata[11:0]) & tsl_pkg::ANA_USED_MASK))
    else $error("analog control not written");
  a_slave_cause: assert property (!$stable(slave_sequence_mask) |-> $past(slv_wr_ff))
    else $error("slave mask changed without write");
  a_master_cause: assert property (!$stable(master_sequence_mask) |-> $past(mst_wr_ff))
    else $error("master mask changed without write");
  a_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside wait");
  a_alert_rise: assert property ($rose(alert) |->
    $past(any_res, 2) || $past(alr_wr_ff, 2))
    else $error("alert rose without cause");
  a_alert_fall: assert property ($fell(alert) |-> $past(alr_wr_ff, 2))
    else $error("alert fell without write");
endmodule

// ---- testbench/tsl_ahb_host.sv ----
// Host processor model that masters single word transfers
`timescale 1ns/10ps
module tsl_ahb_host (
  input logic hclk,
  input logic hready,
  input logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic to_flag
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    to_flag = 1'b0;
  end
  // Waits for ready sampled high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      to_flag <= 1'b1;
    end
  endtask
  // One transfer: address phase, then data phase; called just after an edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= tsl_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata; // Reads leave a changing pattern on write data
    wait_ready();
    q = hrdata;
  endtask
endmodule

// ---- testbench/tb_touch_adc_limit_sequence_dac_regs.sv ----
// Self-checking bench for the limit, sequence and analog output registers
`timescale 1ns/10ps
module tb_touch_adc_limit_sequence_dac_regs;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic to_flag;
  logic alert;
  logic [31:0] q;
  tsl_pkg::tsl_result_t res_b1;
  tsl_pkg::tsl_result_t res_b2;
  tsl_pkg::tsl_result_t res_t;
  tsl_pkg::tsl_slave_seq_t slv_mask;
  tsl_pkg::tsl_master_seq_t mst_mask;
  tsl_pkg::tsl_ana_out_t ana;
  int err_count;
  int n_checks;
  // ----------------------------------------------------------------
  // Clock, instances and hang guard
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  tsl_regs #(.ADDR_W(32)) i_tsl_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .battery_one_result(res_b1), .battery_two_result(res_b2),
    .temperature_result(res_t), .slave_sequence_mask(slv_mask),
    .master_sequence_mask(mst_mask), .analog_out_control(ana), .alert(alert));
  tsl_ahb_host i_tsl_ahb_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .to_flag(to_flag));
  always @(posedge to_flag) begin
    err_count++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks made %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] addr(input logic [4:0] i);
    return {25'h0, i, 2'h0};
  endfunction
  function automatic logic [11:0] used(input logic [4:0] i);
    if (i == 5'h0C || i == 5'h0D) return 12'hFFE;
    if (i == 5'h0E) return 12'hFFD;
    return 12'hFFF;
  endfunction
  function automatic logic [31:0] pat(input logic [4:0] i);
    return 32'hFFFFF001 | ({27'h0, i} * 32'h123);
  endfunction
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    i_tsl_ahb_host.xfer(1'b1, addr(i), d, q);
  endtask
  task automatic rd(input logic [4:0] i);
    i_tsl_ahb_host.xfer(1'b0, addr(i), 32'h0, q);
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // Result pulse on one channel; returns once a following alert has landed
  task automatic pulse(input int ch, input logic [11:0] v);
    if (ch == 1) res_b1 <= {1'b1, v};
    else if (ch == 2) res_b2 <= {1'b1, v};
    else res_t <= {1'b1, v};
    @(posedge hclk);
    res_b1 <= {1'b0, ~res_b1.data};
    res_b2 <= {1'b0, ~res_b2.data};
    res_t <= {1'b0, ~res_t.data};
    repeat (2) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({20'h0, ana}, 32'h008);
    chk({20'h0, slv_mask | mst_mask}, 32'h0);
    for (int i = 6; i <= 14; i++) begin
      rd(5'(i));
      chk(q, (i == 14) ? 32'h008 : 32'h0);
    end
  endtask
  task automatic t_rw();
    for (int i = 6; i <= 14; i++) begin
      wr(5'(i), pat(5'(i)));
    end
    for (int i = 6; i <= 14; i++) begin
      rd(5'(i));
      chk(q, pat(5'(i)) & {20'h0, used(5'(i))});
    end
    chk({20'h0, slv_mask}, pat(5'h0C) & 32'hFFE);
    chk({20'h0, mst_mask}, pat(5'h0D) & 32'hFFE);
  endtask
  task automatic t_dac();
    wr(5'h0E, 32'h000005A5);
    rd(5'h0E);
    chk(q, 32'h000005A5);
    chk({24'h0, ana.analog_code}, 32'h5A);
    chk({29'h0, ana.analog_out_sleep, ana.current_mode, ana.full_span}, 32'h3);
    wr(5'h0E, 32'h00000A0A);
    #1;
    chk({20'h0, ana}, 32'h00000A08);
    @(posedge hclk);
  endtask
  task automatic t_unmapped();
    wr(5'h0F, 32'hFFFFFFFF);
    i_tsl_ahb_host.xfer(1'b1, 32'h00000098, 32'hFFFFFFFF, q);
    rd(5'h0F);
    chk(q, 32'h0);
    i_tsl_ahb_host.xfer(1'b0, 32'h00000098, 32'h0, q);
    chk(q, 32'h0);
    rd(5'h06);
    chk(q, 32'h0);
  endtask
  task automatic t_alarm();
    wr(5'h07, 32'h200);
    wr(5'h06, 32'h800);
    wr(5'h03, 32'h200);
    pulse(1, 12'h200);
    chk({31'h0, alert}, 32'h0);
    pulse(1, 12'h1FF);
    chk({31'h0, alert}, 32'h1);
    rd(5'h03);
    chk(q, 32'h202);
    wr(5'h03, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, alert}, 32'h0);
    pulse(1, 12'hFFF);
    pulse(2, 12'h001);
    pulse(3, 12'h001);
    chk({31'h0, alert}, 32'h0);
    rd(5'h03);
    chk(q, 32'h0E0);
    wr(5'h03, 32'h800);
    pulse(3, 12'h002);
    chk({31'h0, alert}, 32'h1);
    rd(5'h03);
    chk(q, 32'h880);
    // Under flags of battery two and temperature trip below their low limits
    wr(5'h09, 32'h100);
    wr(5'h0A, 32'h100);
    pulse(2, 12'h0FF);
    pulse(3, 12'h0FF);
    rd(5'h03);
    chk(q, 32'h8CC);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    res_b1 = '0;
    res_b2 = '0;
    res_t = '0;
    err_count = 0;
    n_checks = 0;
    do_reset();
    t_reset();
    t_rw();
    do_reset();
    t_reset();
    t_dac();
    t_unmapped();
    t_alarm();
    wrap_up();
  end
endmodule
bind tsl_regs tsl_regs_checker #(.ADDR_W(ADDR_W)) i_tsl_regs_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .battery_one_result(battery_one_result),
  .battery_two_result(battery_two_result), .temperature_result(temperature_result),
  .slave_sequence_mask(slave_sequence_mask), .master_sequence_mask(master_sequence_mask),
  .analog_out_control(analog_out_control), .alert(alert));
